/* adps_line_model.sv */
`timescale 1ns/100ps
module adps_line_model (
	// Driver side
	input  wire logic tx_pos,
	input  wire logic tx_neg,
	// Receiver side
	output logic      rx_pos,
	output logic      rx_neg
);
	// Driver and receiver pass the pair through with a 2 ns delay on both lines; null stays null
	assign #2 rx_pos = tx_pos;
	assign #2 rx_neg = tx_neg;
endmodule

/* adps_mem.sv */
`timescale 1ns/100ps
module adps_mem #(
	parameter int W     = 32,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock
	input  wire logic          clk,
	input  wire logic          ce,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read port
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule

/* adps_pkg.sv */
package adps_pkg;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int CH_N       = 2;
	localparam int MB_N       = 3;
	localparam int LBL_W      = 8;
	localparam int LBL_LSB    = 24;
	localparam int PL_W       = MB_N * LBL_W;
	localparam int RATE_BIT   = 0;
	localparam int OP_RD_BIT  = 7;
	localparam int SPI_SR_W   = 40;
	localparam int STAT_W     = 16;
	localparam int ASN_STRIDE = 4;
	localparam int ASN_INT    = 0;
	localparam int ASN_FLAG   = 2;

	localparam logic [5:0] SPI_LEN_OP   = 6'h08;
	localparam logic [5:0] SPI_LEN_BYTE = 6'h10;
	localparam logic [5:0] SPI_LEN_WORD = 6'h28;
	localparam logic [5:0] LAST_BIT     = 6'h1F;
	localparam logic [5:0] GAP_LAST     = 6'h07;

	// Register byte offsets
	localparam logic [7:0] OFF_TXCTRL  = 8'h00;
	localparam logic [7:0] OFF_FLAGASN = 8'h04;
	localparam logic [7:0] OFF_TXDATA  = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [7:0] OFF_RX1WORD = 8'h10;
	localparam logic [7:0] OFF_RX2WORD = 8'h14;
	localparam logic [7:0] OFF_PLABEL1 = 8'h18;
	localparam logic [7:0] OFF_PLABEL2 = 8'h1C;
	localparam logic [7:0] OFF_MBCLR   = 8'h20;
	localparam logic [7:0] OFF_CLEAR   = 8'h24;

	localparam logic [7:0]  RST_TXCTRL  = 8'h00;
	localparam logic [7:0]  RST_FLAGASN = 8'h00;
	localparam logic [23:0] RST_PLABEL  = 24'h00_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Host serial instruction codes
	localparam logic [7:0] OP_MRESET    = 8'h04;
	localparam logic [7:0] OP_WR_TXCTRL = 8'h08;
	localparam logic [7:0] OP_WR_TXFIFO = 8'h0C;
	localparam logic [7:0] OP_WR_ASN    = 8'h34;
	localparam logic [7:0] OP_SRESET    = 8'h44;

	// Synchroniser lanes: receiver c positive at 2c, negative at 2c+1
	localparam int SY_SI   = 4;
	localparam int SY_SCK  = 5;
	localparam int SY_CS   = 6;
	localparam int SY_LCLK = 7;
	localparam int SY_CLR  = 8;
	localparam int SY_W    = 9;
	localparam logic [SY_W-1:0] SYNC_RST = 9'h040;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_FETCH = 4'h2,
		TX_BIT   = 4'h4,
		TX_GAP   = 4'h8
	} adps_txst_t;

	typedef struct packed {
		logic                   tx_full;
		logic                   tx_empty;
		logic [CH_N-1:0]        rx_valid;
		logic [CH_N*MB_N-1:0]   mbox;
	} adps_stat_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0]        strb;
	} adps_wreq_t;
endpackage

/* adps_top.sv */
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - Hardware clear empties receive paths and transmit FIFO, clears all status flags.
// - Serial bits move on SI and SO only while chip select is low.
// - Each of six mailbox outputs is high while its mailbox holds a message.
// - Transmit-empty output high whenever the transmit FIFO holds no words.
// - Transmit-full output high when the transmit FIFO holds 32 words.
// - Speed-select output follows bit zero of the transmit control register.
// - Speed-select high means low-speed, low means high-speed operation.
// - Each receiver flag rises on conditions picked in the assignment register.
// - Each receiver has its own interrupt output on its programmed conditions.
// - Transmitter drives the serial word as positive and negative logic outputs.
// - Each receiver takes the bus state as positive and negative logic inputs.
// - The protocol timing clock times both receivers and the transmitter.
// - First eight SCK rises after chip select falls shift in the opcode, MSB first.
// - Read data MSB appears on SO at the falling SCK after the opcode.
module adps_top import adps_pkg::*; #(
	parameter int TX_DEPTH  = 32,
	parameter int TX_DIV_HI = 2,
	parameter int TX_DIV_LO = 16,
	parameter int RX_RESYNC = 64
) (
	// System
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [DATA_W-1:0] rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Host serial port
	input  wire logic              spi_cs_n,
	input  wire logic              spi_sck,
	input  wire logic              spi_si,
	output logic                   spi_so,
	// Link pins
	input  wire logic              arinc_clk,
	input  wire logic              hw_clear_pulse,
	input  wire logic              rx1_logic_in_pos,
	input  wire logic              rx1_logic_in_neg,
	input  wire logic              rx2_logic_in_pos,
	input  wire logic              rx2_logic_in_neg,
	output logic                   tx_logic_out_pos,
	output logic                   tx_logic_out_neg,
	output logic                   tx_speed_select_out,
	// Status pins
	output logic                   rx1_mailbox_a_full,
	output logic                   rx1_mailbox_b_full,
	output logic                   rx1_mailbox_c_full,
	output logic                   rx2_mailbox_a_full,
	output logic                   rx2_mailbox_b_full,
	output logic                   rx2_mailbox_c_full,
	output logic                   rx1_irq_out,
	output logic                   rx2_irq_out,
	output logic                   rx1_assigned_status_out,
	output logic                   rx2_assigned_status_out,
	output logic                   tx_queue_empty_out,
	output logic                   tx_queue_full_out
);
	localparam int AW  = $clog2(TX_DEPTH);
	localparam int CW  = AW + 1;
	localparam int DVW = $clog2(TX_DIV_LO + TX_DIV_HI) + 1;
	localparam int RSW = $clog2(RX_RESYNC) + 1;
	localparam logic [CW-1:0]  FULL_CNT = CW'(TX_DEPTH);
	localparam logic [DVW-1:0] DIV_HI   = DVW'(TX_DIV_HI - 1);
	localparam logic [DVW-1:0] DIV_LO   = DVW'(TX_DIV_LO - 1);
	localparam logic [RSW-1:0] RESYNC   = RSW'(RX_RESYNC);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] meta_q;
	logic [SY_W-1:0] sync_q;
	logic [SY_W-1:0] prev_q;
	assign raw = {hw_clear_pulse, arinc_clk, spi_cs_n, spi_sck, spi_si,
		rx2_logic_in_neg, rx2_logic_in_pos, rx1_logic_in_neg, rx1_logic_in_pos};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= SYNC_RST;
			sync_q <= SYNC_RST;
			prev_q <= SYNC_RST;
		end else if (ce) begin
			meta_q <= raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	wire logic cs_n      = sync_q[SY_CS];
	wire logic cs_rise   = sync_q[SY_CS] & ~prev_q[SY_CS];
	wire logic sck_rise  = sync_q[SY_SCK] & ~prev_q[SY_SCK];
	wire logic sck_fall  = ~sync_q[SY_SCK] & prev_q[SY_SCK];
	wire logic lclk_rise = sync_q[SY_LCLK] & ~prev_q[SY_LCLK];

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic              aw_q, w_q, bvalid_q, rvalid_q;
	logic [1:0]        bresp_q, rresp_q;
	logic [DATA_W-1:0] rdata_q, rd_val;
	adps_wreq_t        wreq_q;
	logic [7:0]        txctrl_q, asn_q;
	logic [2*PL_W-1:0] plabel_q;
	logic              empty_q, full_q, clr;
	logic [CH_N-1:0]   rx_val, rx_flag, rx_irq;
	logic [CH_N*MB_N-1:0] rx_mb;
	logic [CH_N*DATA_W-1:0] rx_word;
	adps_stat_t        stat;

	assign awready = ~aw_q & ~bvalid_q;
	assign wready  = ~w_q & ~bvalid_q;
	assign arready = ~rvalid_q;
	wire logic aw_hs = awvalid & awready;
	wire logic w_hs  = wvalid & wready;
	wire logic ar_hs = arvalid & arready;
	wire logic wr_go = aw_q & w_q;

	wire logic [ADDR_W-1:0] wa = wreq_q.addr;
	wire logic [DATA_W-1:0] wmask = {{8{wreq_q.strb[3]}}, {8{wreq_q.strb[2]}},
		{8{wreq_q.strb[1]}}, {8{wreq_q.strb[0]}}};
	wire logic [DATA_W-1:0] wd = wreq_q.data;
	wire logic wr_txctrl = wr_go & (wa == OFF_TXCTRL);
	wire logic wr_asn    = wr_go & (wa == OFF_FLAGASN);
	wire logic wr_txdata = wr_go & (wa == OFF_TXDATA);
	wire logic wr_pl1    = wr_go & (wa == OFF_PLABEL1);
	wire logic wr_pl2    = wr_go & (wa == OFF_PLABEL2);
	wire logic wr_mbclr  = wr_go & (wa == OFF_MBCLR);
	wire logic wr_clear  = wr_go & (wa == OFF_CLEAR);
	wire logic wa_hit = (wa == OFF_TXCTRL) | (wa == OFF_FLAGASN) | (wa == OFF_TXDATA) |
		(wa == OFF_PLABEL1) | (wa == OFF_PLABEL2) | (wa == OFF_MBCLR) | (wa == OFF_CLEAR);
	// A push into a full FIFO is dropped and answered with an error
	wire logic wr_err = ~wa_hit | ((wa == OFF_TXDATA) & full_q);
	wire logic [CH_N*MB_N-1:0] mbclr_bits = {(CH_N*MB_N){wr_mbclr}} & wd[CH_N*MB_N-1:0];

	wire logic rd_hit = (araddr == OFF_TXCTRL) | (araddr == OFF_FLAGASN) | (araddr == OFF_STATUS) |
		(araddr == OFF_RX1WORD) | (araddr == OFF_RX2WORD) | (araddr == OFF_PLABEL1) |
		(araddr == OFF_PLABEL2);
	wire logic [CH_N-1:0] rd_rx = {ar_hs & (araddr == OFF_RX2WORD), ar_hs & (araddr == OFF_RX1WORD)};
	assign rd_val = (araddr == OFF_TXCTRL)  ? {24'h00_0000, txctrl_q} :
		(araddr == OFF_FLAGASN) ? {24'h00_0000, asn_q} :
		(araddr == OFF_STATUS)  ? {22'h00_0000, stat} :
		(araddr == OFF_RX1WORD) ? rx_word[DATA_W-1:0] :
		(araddr == OFF_RX2WORD) ? rx_word[2*DATA_W-1:DATA_W] :
		(araddr == OFF_PLABEL1) ? {8'h00, plabel_q[PL_W-1:0]} :
		(araddr == OFF_PLABEL2) ? {8'h00, plabel_q[2*PL_W-1:PL_W]} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b0; rvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY; rresp_q <= RESP_OKAY; rdata_q <= '0; wreq_q <= '0;
		end else if (ce) begin
			if (aw_hs) begin
				aw_q <= 1'b1;
				wreq_q.addr <= awaddr;
			end else if (wr_go) aw_q <= 1'b0;
			if (w_hs) begin
				w_q <= 1'b1;
				wreq_q.data <= wdata;
				wreq_q.strb <= wstrb;
			end else if (wr_go) w_q <= 1'b0;
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bready) bvalid_q <= 1'b0;
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_val;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) rvalid_q <= 1'b0;
		end
	end
	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp  = rresp_q;
	assign rdata  = rdata_q;

	// ----------------------------------------------------------------
	// Host serial port
	// ----------------------------------------------------------------
	logic [5:0]          spi_cnt_q;
	logic [SPI_SR_W-1:0] spi_in_q;
	logic [STAT_W-1:0]   spi_out_q;
	logic                spi_rd_q, so_q;
	wire logic spi_len_b  = spi_cnt_q == SPI_LEN_BYTE;
	wire logic spi_txctrl = cs_rise & spi_len_b & (spi_in_q[15:8] == OP_WR_TXCTRL);
	wire logic spi_asn    = cs_rise & spi_len_b & (spi_in_q[15:8] == OP_WR_ASN);
	wire logic spi_push   = cs_rise & (spi_cnt_q == SPI_LEN_WORD) & (spi_in_q[39:32] == OP_WR_TXFIFO);
	wire logic spi_clr    = cs_rise & (spi_cnt_q == SPI_LEN_OP) &
		((spi_in_q[7:0] == OP_SRESET) | (spi_in_q[7:0] == OP_MRESET));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spi_cnt_q <= '0; spi_in_q <= '0; spi_out_q <= '0; spi_rd_q <= 1'b0; so_q <= 1'b0;
		end else if (ce) begin
			if (cs_n) begin
				spi_cnt_q <= '0;
				spi_rd_q <= 1'b0;
				so_q <= 1'b0;
			end else if (sck_rise) begin
				spi_in_q <= {spi_in_q[SPI_SR_W-2:0], sync_q[SY_SI]};
				if (spi_cnt_q != '1) spi_cnt_q <= spi_cnt_q + 6'h01;
				if (spi_cnt_q == SPI_LEN_OP - 6'h01 && spi_in_q[OP_RD_BIT-1]) begin
					spi_rd_q <= 1'b1;
					spi_out_q <= {6'h00, stat};
				end
			end else if (sck_fall && spi_rd_q) begin
				so_q <= spi_out_q[STAT_W-1];
				spi_out_q <= {spi_out_q[STAT_W-2:0], 1'b0};
			end
		end
	end
	assign spi_so = so_q;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	assign clr = sync_q[SY_CLR] | wr_clear | spi_clr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txctrl_q <= RST_TXCTRL; asn_q <= RST_FLAGASN; plabel_q <= {RST_PLABEL, RST_PLABEL};
		end else if (ce) begin
			if (wr_txctrl) txctrl_q <= (txctrl_q & ~wmask[7:0]) | (wd[7:0] & wmask[7:0]);
			else if (spi_txctrl) txctrl_q <= spi_in_q[7:0];
			if (wr_asn) asn_q <= (asn_q & ~wmask[7:0]) | (wd[7:0] & wmask[7:0]);
			else if (spi_asn) asn_q <= spi_in_q[7:0];
			if (wr_pl1) plabel_q[PL_W-1:0] <= (plabel_q[PL_W-1:0] & ~wmask[PL_W-1:0]) |
				(wd[PL_W-1:0] & wmask[PL_W-1:0]);
			if (wr_pl2) plabel_q[2*PL_W-1:PL_W] <= (plabel_q[2*PL_W-1:PL_W] & ~wmask[PL_W-1:0]) |
				(wd[PL_W-1:0] & wmask[PL_W-1:0]);
		end
	end
	assign tx_speed_select_out = txctrl_q[RATE_BIT];

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	logic [AW-1:0]     wp_q, rp_q;
	logic [CW-1:0]     cnt_q, cnt_d;
	logic [DATA_W-1:0] mem_rdata;
	logic              pop;
	// The bus wins a same-cycle push; the serial push is then lost
	wire logic push_req = wr_txdata | spi_push;
	wire logic [DATA_W-1:0] push_data = wr_txdata ? wd : spi_in_q[DATA_W-1:0];
	wire logic push = push_req & (cnt_q != FULL_CNT) & ~clr;
	assign cnt_d = clr ? '0 : cnt_q + CW'(push) - CW'(pop);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_q <= '0; rp_q <= '0; cnt_q <= '0; empty_q <= 1'b1; full_q <= 1'b0;
		end else if (ce) begin
			wp_q <= clr ? '0 : wp_q + AW'(push);
			rp_q <= clr ? '0 : rp_q + AW'(pop);
			cnt_q <= cnt_d;
			empty_q <= cnt_d == '0;
			full_q <= cnt_d == FULL_CNT;
		end
	end
	assign tx_queue_empty_out = empty_q;
	assign tx_queue_full_out  = full_q;

	adps_mem #(.W(DATA_W), .DEPTH(TX_DEPTH)) u_mem (
		.clk   (aclk),
		.ce    (ce),
		.we    (push),
		.waddr (wp_q),
		.wdata (push_data),
		.raddr (rp_q),
		.rdata (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	adps_txst_t        st_q, st_d;
	logic              ph_q, ph_d, tpos_q, tneg_q;
	logic [5:0]        nb_q, nb_d;
	logic [DATA_W-1:0] tsh_q, tsh_d;
	logic [DVW-1:0]    div_q;
	// Each half bit lasts a programmable number of link clock rises
	wire logic [DVW-1:0] div_lim = txctrl_q[RATE_BIT] ? DIV_LO : DIV_HI;
	wire logic tx_tick = lclk_rise & (div_q == div_lim);

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		nb_d = nb_q;
		tsh_d = tsh_q;
		pop = 1'b0;
		case (st_q)
			TX_IDLE: if (cnt_q != '0) st_d = TX_FETCH;
			TX_FETCH: begin
				tsh_d = mem_rdata;
				pop = 1'b1;
				ph_d = 1'b0;
				nb_d = '0;
				st_d = TX_BIT;
			end
			TX_BIT: if (tx_tick) begin
				ph_d = ~ph_q;
				if (ph_q) begin
					tsh_d = {tsh_q[DATA_W-2:0], 1'b0};
					nb_d = nb_q + 6'h01;
					if (nb_q == LAST_BIT) begin
						nb_d = '0;
						st_d = TX_GAP;
					end
				end
			end
			TX_GAP: if (tx_tick) begin
				nb_d = nb_q + 6'h01;
				if (nb_q == GAP_LAST) st_d = TX_IDLE;
			end
			default: st_d = TX_IDLE;
		endcase
		if (clr) begin
			st_d = TX_IDLE;
			pop = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= TX_IDLE; ph_q <= 1'b0; nb_q <= '0; tsh_q <= '0; div_q <= '0;
			tpos_q <= 1'b0; tneg_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d; ph_q <= ph_d; nb_q <= nb_d; tsh_q <= tsh_d;
			if (st_q == TX_FETCH || tx_tick) div_q <= '0;
			else if (lclk_rise) div_q <= div_q + DVW'(1);
			tpos_q <= (st_d == TX_BIT) & ~ph_d & tsh_d[DATA_W-1];
			tneg_q <= (st_d == TX_BIT) & ~ph_d & ~tsh_d[DATA_W-1];
		end
	end
	assign tx_logic_out_pos = tpos_q;
	assign tx_logic_out_neg = tneg_q;

	// ----------------------------------------------------------------
	// Receivers, mailboxes, flag and interrupt pins
	// ----------------------------------------------------------------
	for (genvar c = 0; c < CH_N; c++) begin : g_rx
		logic [DATA_W-1:0] sh_q, word_q;
		logic [5:0]        bits_q;
		logic [RSW-1:0]    idle_q;
		logic [1:0]        lvl_q;
		logic              val_q, flag_q, irq_q;
		logic [MB_N-1:0]   mb_q, hit;
		wire logic [1:0] lvl = {sync_q[2*c], sync_q[2*c+1]};
		wire logic bit_ev = lclk_rise & (lvl_q == '0) & (^lvl);
		wire logic [DATA_W-1:0] sh_n = {sh_q[DATA_W-2:0], lvl[1]};
		wire logic done = bit_ev & (bits_q == LAST_BIT);
		for (genvar k = 0; k < MB_N; k++) begin : g_mb
			assign hit[k] = sh_n[LBL_LSB +: LBL_W] == plabel_q[c*PL_W + k*LBL_W +: LBL_W];
		end
		wire logic mb_any = |mb_q;
		wire logic [3:0] cond = {val_q | mb_any, mb_any, mb_q[0], val_q};
		wire logic fcond = cond[asn_q[c*ASN_STRIDE+ASN_FLAG +: 2]];
		wire logic icond = cond[asn_q[c*ASN_STRIDE+ASN_INT +: 2]];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				sh_q <= '0; word_q <= '0; bits_q <= '0; idle_q <= '0; lvl_q <= '0;
				val_q <= 1'b0; flag_q <= 1'b0; irq_q <= 1'b0; mb_q <= '0;
			end else if (ce) begin
				if (lclk_rise) lvl_q <= lvl;
				if (bit_ev) sh_q <= sh_n;
				if (clr || done) bits_q <= '0;
				else if (bit_ev) bits_q <= bits_q + 6'h01;
				else if (idle_q == RESYNC) bits_q <= '0;
				if (clr || (lclk_rise && lvl != '0)) idle_q <= '0;
				else if (lclk_rise && idle_q != RESYNC) idle_q <= idle_q + RSW'(1);
				if (done && hit == '0) word_q <= sh_n;
				if (clr) val_q <= 1'b0;
				else if (done && hit == '0) val_q <= 1'b1;
				else if (rd_rx[c]) val_q <= 1'b0;
				if (clr) mb_q <= '0;
				else mb_q <= (mb_q & ~mbclr_bits[c*MB_N +: MB_N]) | ({MB_N{done}} & hit);
				flag_q <= fcond & ~clr;
				irq_q <= icond & ~clr;
			end
		end
		assign rx_val[c] = val_q;
		assign rx_flag[c] = flag_q;
		assign rx_irq[c] = irq_q;
		assign rx_mb[c*MB_N +: MB_N] = mb_q;
		assign rx_word[c*DATA_W +: DATA_W] = word_q;
	end

	assign stat = '{tx_full: full_q, tx_empty: empty_q, rx_valid: rx_val, mbox: rx_mb};
	assign {rx2_mailbox_c_full, rx2_mailbox_b_full, rx2_mailbox_a_full,
		rx1_mailbox_c_full, rx1_mailbox_b_full, rx1_mailbox_a_full} = rx_mb;
	assign rx1_assigned_status_out = rx_flag[0];
	assign rx2_assigned_status_out = rx_flag[1];
	assign rx1_irq_out = rx_irq[0];
	assign rx2_irq_out = rx_irq[1];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	clear_empties_a: assert property (clr && ce |=> tx_queue_empty_out && rx_mb == '0 && rx_val == '0)
		else $error("clear left data or flags");
	clear_holds_a: assert property (sync_q[SY_CLR] && ce |=> !rx1_irq_out && !rx2_assigned_status_out)
		else $error("flag set during clear");
	so_quiet_a: assert property (cs_n && ce |=> !spi_so)
		else $error("SO driven while deselected");
	empty_flag_a: assert property (tx_queue_empty_out == (cnt_q == '0))
		else $error("empty flag disagrees with count");
	full_flag_a: assert property (tx_queue_full_out == (cnt_q == FULL_CNT))
		else $error("full flag disagrees with count");
	speed_follow_a: assert property (wr_txctrl && wreq_q.strb[0] && ce |=>
		tx_speed_select_out == $past(wd[RATE_BIT]))
		else $error("speed select missed write");
	mbox_cause_a: assert property ($rose(rx1_mailbox_a_full) |-> $past(g_rx[0].done))
		else $error("mailbox set without word");
	op_length_a: assert property ($rose(spi_rd_q) |-> spi_cnt_q == SPI_LEN_OP)
		else $error("read opcode not after eight bits");
	tx_idle_quiet_a: assert property (st_q == TX_IDLE |-> !tx_logic_out_pos && !tx_logic_out_neg)
		else $error("line driven while idle");
	flag_sel_a: assert property (ce && !clr |=> rx1_assigned_status_out == $past(g_rx[0].fcond))
		else $error("flag ignores assignment");
	irq_sel_a: assert property (ce && !clr |=> rx2_irq_out == $past(g_rx[1].icond))
		else $error("interrupt ignores assignment");

	full_seen_c: cover property (tx_queue_full_out);
	word_seen_c: cover property (g_rx[1].done && g_rx[1].hit == '0);
	spi_read_c: cover property ($rose(spi_rd_q) ##[1:200] sck_fall);
	tx_word_c: cover property (st_q == TX_GAP);
endmodule

/* testbench.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module testbench import adps_pkg::*;;
	logic        aclk = 0, aresetn = 0, arinc_clk = 0, hw_clr = 0, ce = 1;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, cs_n = 1, sck = 0, si = 0, so;
	logic [1:0]  bresp, rresp, r;
	logic        tp, tn, lp, ln, spd, mb1a, mb1b, irq1, irq2, flg1, flg2, emp, ful, mb[4];
	logic [15:0] q;
	int          fail_count = 0, tests_run = 0, k;
	always #2 aclk = ~aclk;
	always #62.5 arinc_clk = ~arinc_clk;
	adps_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .spi_cs_n(cs_n), .spi_sck(sck),
		.spi_si(si), .spi_so(so), .arinc_clk(arinc_clk), .hw_clear_pulse(hw_clr), .rx1_logic_in_pos(lp),
		.rx1_logic_in_neg(ln), .rx2_logic_in_pos(lp), .rx2_logic_in_neg(ln), .tx_logic_out_pos(tp),
		.tx_logic_out_neg(tn), .tx_speed_select_out(spd), .rx1_mailbox_a_full(mb1a),
		.rx1_mailbox_b_full(mb1b), .rx1_mailbox_c_full(mb[0]), .rx2_mailbox_a_full(mb[1]),
		.rx2_mailbox_b_full(mb[2]), .rx2_mailbox_c_full(mb[3]), .rx1_irq_out(irq1), .rx2_irq_out(irq2),
		.rx1_assigned_status_out(flg1), .rx2_assigned_status_out(flg2), .tx_queue_empty_out(emp),
		.tx_queue_full_out(ful));
	adps_line_model i_line (.tx_pos(tp), .tx_neg(tn), .rx_pos(lp), .rx_neg(ln));
	// ----------------------------------------
	// Bus and serial tasks
	// ----------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task tmo;
		fail_count++;
		summarize;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		if (k == 50) tmo;
		r = bresp; bready <= 0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		if (k == 50) tmo;
		`CHK(rdata, e)
		rready <= 0;
		@(posedge aclk);
	endtask
	// Slow SCK: every level spans at least four system clocks, so the synchroniser sees it
	task spi(input logic [39:0] v, input int n);
		cs_n <= 0;
		for (int i = 0; i < n; i++) begin
			si <= v[n-1-i];
			repeat (4) @(posedge aclk); sck <= 1;
			repeat (4) @(posedge aclk); sck <= 0;
			repeat (4) @(posedge aclk);
			if (i > 6 && i < 23) q = {q[14:0], so};
		end
		cs_n <= 1;
		repeat (5) @(posedge aclk);
		`CHK(so, 1'b0)
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		`CHK({emp, ful, spd}, 3'b100)
		rd(OFF_STATUS, 32'h0000_0100);
		wr(OFF_PLABEL1, 32'h0000_00A5);
		wr(OFF_FLAGASN, 32'h0000_0009);
		wr(OFF_TXDATA, 32'hA500_0123);
		`CHK(r, RESP_OKAY)
		for (k = 0; k < 20000 && mb1a !== 1'b1; k++) @(posedge aclk);
		if (k == 20000) tmo;
		repeat (40) @(posedge aclk);
		`CHK({mb1a, mb1b, mb[0], mb[1], mb[2], mb[3], irq1, flg1, irq2, flg2}, 10'h20F)
		spi(40'h80_0000, 24);
		`CHK(q, 16'h0181)
		rd(OFF_STATUS, 32'h0000_0181);
		rd(OFF_RX2WORD, 32'hA500_0123);
		wr(OFF_MBCLR, 32'h0000_0001);
		spi(40'h0801, 16);
		repeat (4) @(posedge aclk);
		`CHK({spd, irq2, mb1a, irq1, flg1}, 5'h10)
		rd(OFF_TXCTRL, 32'h0000_0001);
		// Let the gap after the first word run out, so the first queued word is taken at once
		repeat (1500) @(posedge aclk);
		repeat (33) wr(OFF_TXDATA, 32'h0000_0011);
		`CHK({ful, emp, r}, {2'h2, RESP_OKAY})
		wr(OFF_TXDATA, 32'h0000_0022);
		`CHK(r, RESP_SLVERR)
		wr(OFF_TXCTRL, 32'h0000_0000);
		`CHK({spd, r}, {1'h0, RESP_OKAY})
		// Clock enable low must freeze the queue even with clear raised
		ce <= 0;
		hw_clr <= 1;
		repeat (6) @(posedge aclk);
		`CHK({ful, emp}, 2'h2)
		ce <= 1;
		repeat (6) @(posedge aclk);
		`CHK({emp, ful, mb1a, irq1, irq2}, 5'h10)
		hw_clr <= 0;
		summarize;
	end
endmodule
